/* File: pkg/rxpl_params.svh */
// register offsets, field positions and reset values of the receive lane output block
// assumes an 8-bit apb byte address and 32-bit data
`ifndef RXPL_PARAMS_SVH
`define RXPL_PARAMS_SVH

// register byte offsets
`define RXPL_OFF_CTRL   8'h00
`define RXPL_OFF_STAT   8'h04
`define RXPL_OFF_MASK   8'h08
`define RXPL_OFF_LANE   8'h0c

// control field positions
`define RXPL_CTRL_CODE  0
`define RXPL_CTRL_SYNC  1

// status and mask field positions (four lanes each)
`define RXPL_STAT_ERR   0
`define RXPL_STAT_KCH   4

// reset values
`define RXPL_RST_CTRL   2'h0
`define RXPL_RST_STAT   8'h00
`define RXPL_RST_MASK   8'h00
`define RXPL_RST_RD     1'b0

`endif

/* File: pkg/rxpl_pkg.sv */
// types shared by the receive lane output block
// assumes nothing beyond a systemverilog compiler
package rxpl_pkg;

  // one received half-word as presented on the parallel pins
  typedef struct packed {
    logic [7:0] data;
    logic       bit8;
    logic       bit9;
  } rxpl_sym_s;

  // decoder result with the running disparity that follows the symbol
  typedef struct packed {
    rxpl_sym_s sym;
    logic      rd;
  } rxpl_dec_s;

endpackage

/* File: src/rxpl_lane_out.sv */
// receive parallel output of four lanes: samples recovered clocks and code groups,
// decodes or passes them through, and drives ddr-style lane pins plus an apb register set
// assumes code groups arrive from the link side, bit 0 first in line order (a..j)
`timescale 1ns/1ps
`include "rxpl_params.svh"

module rxpl_lane_out
  import rxpl_pkg::*;
(
  // apb slave
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // link side: recovered clocks and 10-bit code groups, index 0 is lane a
  input  wire logic [3:0]       lane_rec_clk,
  input  wire logic [3:0][9:0]  lane_rx_code,
  // parallel pins, lane a
  output logic                  lane_a_rx_clock,
  output logic      [7:0]       lane_a_rx_byte,
  output logic                  lane_a_bit8_kflag,
  output logic                  lane_a_bit9_errflag,
  // parallel pins, lane b
  output logic                  lane_b_rx_clock,
  output logic      [7:0]       lane_b_rx_byte,
  output logic                  lane_b_bit8_kflag,
  output logic                  lane_b_bit9_errflag,
  // parallel pins, lane c
  output logic                  lane_c_rx_clock,
  output logic      [7:0]       lane_c_rx_byte,
  output logic                  lane_c_bit8_kflag,
  output logic                  lane_c_bit9_errflag,
  // parallel pins, lane d
  output logic                  lane_d_rx_clock,
  output logic      [7:0]       lane_d_rx_byte,
  output logic                  lane_d_bit8_kflag,
  output logic                  lane_d_bit9_errflag,
  // interrupt
  output logic                  irq
);

  // 8b/10b decode of one code group against the running disparity
  function automatic rxpl_dec_s decode(input logic [9:0] c, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4, t4;
    logic [4:0] v5;
    logic [2:0] v3, n6, n4;
    logic       ok6, ok4, k28, kx, err, r;
    rxpl_dec_s  res;
    s6  = {c[0], c[1], c[2], c[3], c[4], c[5]};
    s4  = {c[6], c[7], c[8], c[9]};
    v5  = 5'h00;
    v3  = 3'h0;
    ok6 = 1'b1;
    ok4 = 1'b1;
    k28 = 1'b0;
    case (s6)
      6'b100111, 6'b011000: v5 = 5'h00;
      6'b011101, 6'b100010: v5 = 5'h01;
      6'b101101, 6'b010010: v5 = 5'h02;
      6'b110001:            v5 = 5'h03;
      6'b110101, 6'b001010: v5 = 5'h04;
      6'b101001:            v5 = 5'h05;
      6'b011001:            v5 = 5'h06;
      6'b111000, 6'b000111: v5 = 5'h07;
      6'b111001, 6'b000110: v5 = 5'h08;
      6'b100101:            v5 = 5'h09;
      6'b010101:            v5 = 5'h0a;
      6'b110100:            v5 = 5'h0b;
      6'b001101:            v5 = 5'h0c;
      6'b101100:            v5 = 5'h0d;
      6'b011100:            v5 = 5'h0e;
      6'b010111, 6'b101000: v5 = 5'h0f;
      6'b011011, 6'b100100: v5 = 5'h10;
      6'b100011:            v5 = 5'h11;
      6'b010011:            v5 = 5'h12;
      6'b110010:            v5 = 5'h13;
      6'b001011:            v5 = 5'h14;
      6'b101010:            v5 = 5'h15;
      6'b011010:            v5 = 5'h16;
      6'b111010, 6'b000101: v5 = 5'h17;
      6'b110011, 6'b001100: v5 = 5'h18;
      6'b100110:            v5 = 5'h19;
      6'b010110:            v5 = 5'h1a;
      6'b110110, 6'b001001: v5 = 5'h1b;
      6'b001110:            v5 = 5'h1c;
      6'b101110, 6'b010001: v5 = 5'h1d;
      6'b011110, 6'b100001: v5 = 5'h1e;
      6'b101011, 6'b010100: v5 = 5'h1f;
      6'b001111, 6'b110000: begin
        v5  = 5'h1c;
        k28 = 1'b1;
      end
      default:              ok6 = 1'b0;
    endcase
    // control characters of the 28 group use their own 3b/4b map
    t4 = (s6 == 6'b001111) ? ~s4 : s4;
    if (k28) begin
      case (t4)
        4'b1011: v3 = 3'h0;
        4'b0110: v3 = 3'h1;
        4'b1010: v3 = 3'h2;
        4'b1100: v3 = 3'h3;
        4'b1101: v3 = 3'h4;
        4'b0101: v3 = 3'h5;
        4'b1001: v3 = 3'h6;
        4'b0111: v3 = 3'h7;
        default: ok4 = 1'b0;
      endcase
    end else begin
      case (s4)
        4'b1011, 4'b0100:                   v3 = 3'h0;
        4'b1001:                            v3 = 3'h1;
        4'b0101:                            v3 = 3'h2;
        4'b1100, 4'b0011:                   v3 = 3'h3;
        4'b1101, 4'b0010:                   v3 = 3'h4;
        4'b1010:                            v3 = 3'h5;
        4'b0110:                            v3 = 3'h6;
        4'b1110, 4'b0001, 4'b0111, 4'b1000: v3 = 3'h7;
        default:                            ok4 = 1'b0;
      endcase
    end
    kx = ok6 && !k28 && (s4 == 4'b0111 || s4 == 4'b1000) &&
         (v5 == 5'h17 || v5 == 5'h1b || v5 == 5'h1d || v5 == 5'h1e);
    // running disparity check and update, six-bit block then four-bit block
    n6  = 3'($countones(s6));
    n4  = 3'($countones(s4));
    r   = rd;
    err = (n6 == 3'd4 && r) || (n6 == 3'd2 && !r) ||
          (s6 == 6'b111000 && r) || (s6 == 6'b000111 && !r);
    r   = (n6 > 3'd3) ? 1'b1 : ((n6 < 3'd3) ? 1'b0 : r);
    err = err || (n4 == 3'd3 && r) || (n4 == 3'd1 && !r) ||
          (s4 == 4'b1100 && r) || (s4 == 4'b0011 && !r);
    r   = (n4 > 3'd2) ? 1'b1 : ((n4 < 3'd2) ? 1'b0 : r);
    res.sym.data = {v3, v5};
    res.sym.bit8 = ok6 && ok4 && (k28 || kx);
    res.sym.bit9 = !ok6 || !ok4 || err || (n6 < 3'd2) || (n6 > 3'd4) ||
                   (n4 < 3'd1) || (n4 > 3'd3);
    res.rd       = r;
    return res;
  endfunction

  logic [3:0]       clk_s1_r, clk_s2_r, clk_s3_r;
  logic [3:0]       lvl_r, edge_det, cap, rd_r, clk_out_r;
  logic [3:0][9:0]  code_s1_r, code_s2_r, code_s3_r;
  rxpl_sym_s [3:0]  sym_r;
  rxpl_dec_s [3:0]  dec;
  logic             code_mode_r, sync_mode_r, pready_r, pslverr_r, irq_r;
  logic             acc, wr, rd_stat, mapped;
  logic [7:0]       stat_r, mask_r, stat_set;
  logic [31:0]      prdata_r, rdata_nxt;

  // three-stage sampling of recovered clocks and code groups from the link side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_r  <= 4'h0;
      clk_s2_r  <= 4'h0;
      clk_s3_r  <= 4'h0;
      code_s1_r <= '0;
      code_s2_r <= '0;
      code_s3_r <= '0;
    end else begin
      clk_s1_r  <= lane_rec_clk;
      clk_s2_r  <= clk_s1_r;
      clk_s3_r  <= clk_s2_r;
      code_s1_r <= lane_rx_code;
      code_s2_r <= code_s1_r;
      code_s3_r <= code_s2_r;
    end
  end

  // a clock change counts once stages two and three agree; both edges count
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      edge_det[i] = (clk_s2_r[i] == clk_s3_r[i]) && (clk_s3_r[i] != lvl_r[i]);
      cap[i]      = (i == 0 || !sync_mode_r) ? edge_det[i] : edge_det[0];
      dec[i]      = decode(code_s3_r[i], rd_r[i]);
    end
  end

  // filtered clock level per lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (edge_det[i]) begin
          lvl_r[i] <= clk_s3_r[i];
        end
      end
    end
  end

  // capture one symbol per clock edge, raw or decoded per code mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_r <= '0;
      rd_r  <= {4{`RXPL_RST_RD}};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cap[i]) begin
          rd_r[i] <= dec[i].rd;
          if (code_mode_r) begin
            sym_r[i] <= dec[i].sym;
          end else begin
            sym_r[i].data <= code_s3_r[i][7:0];
            sym_r[i].bit8 <= code_s3_r[i][8];
            sym_r[i].bit9 <= code_s3_r[i][9];
          end
        end
      end
    end
  end

  // output clocks follow one cycle behind the data so both edges see it stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_r <= 4'h0;
    end else begin
      clk_out_r[0] <= lvl_r[0];
      for (int i = 1; i < 4; i++) begin
        clk_out_r[i] <= sync_mode_r ? lvl_r[0] : lvl_r[i];
      end
    end
  end

  // apb decode: answer on the second access cycle
  assign acc     = psel && penable && pready_r;
  assign wr      = acc && pwrite;
  assign rd_stat = acc && !pwrite && (paddr == `RXPL_OFF_STAT);
  assign mapped  = (paddr == `RXPL_OFF_CTRL) || (paddr == `RXPL_OFF_STAT) ||
                   (paddr == `RXPL_OFF_MASK) || (paddr == `RXPL_OFF_LANE);

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `RXPL_OFF_CTRL: rdata_nxt = {30'h0, sync_mode_r, code_mode_r};
      `RXPL_OFF_STAT: rdata_nxt = {24'h0, stat_r};
      `RXPL_OFF_MASK: rdata_nxt = {24'h0, mask_r};
      `RXPL_OFF_LANE: rdata_nxt = {24'h0, lvl_r, rd_r};
      default:        rdata_nxt = 32'h0000_0000;
    endcase
  end

  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      if (psel && penable && !pready_r && !pwrite) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  // control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sync_mode_r, code_mode_r} <= `RXPL_RST_CTRL;
      mask_r                     <= `RXPL_RST_MASK;
    end else if (wr) begin
      if (paddr == `RXPL_OFF_CTRL) begin
        code_mode_r <= pwdata[`RXPL_CTRL_CODE];
        sync_mode_r <= pwdata[`RXPL_CTRL_SYNC];
      end
      if (paddr == `RXPL_OFF_MASK) begin
        mask_r <= pwdata[7:0];
      end
    end
  end

  // sticky events, cleared by a status read; a new event wins over the clear
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      stat_set[`RXPL_STAT_ERR + i] = cap[i] && code_mode_r && dec[i].sym.bit9;
      stat_set[`RXPL_STAT_KCH + i] = cap[i] && code_mode_r && dec[i].sym.bit8;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= `RXPL_RST_STAT;
      irq_r  <= 1'b0;
    end else begin
      // a read clears only the bits it returned, so an event landing mid-read survives
      stat_r <= (rd_stat ? (stat_r & ~prdata_r[7:0]) : stat_r) | stat_set;
      irq_r  <= |(stat_r & mask_r);
    end
  end

  // pin mapping, lane a is the low byte of the host word
  assign lane_a_rx_clock     = clk_out_r[0];
  assign lane_a_rx_byte      = sym_r[0].data;
  assign lane_a_bit8_kflag   = sym_r[0].bit8;
  assign lane_a_bit9_errflag = sym_r[0].bit9;
  assign lane_b_rx_clock     = clk_out_r[1];
  assign lane_b_rx_byte      = sym_r[1].data;
  assign lane_b_bit8_kflag   = sym_r[1].bit8;
  assign lane_b_bit9_errflag = sym_r[1].bit9;
  assign lane_c_rx_clock     = clk_out_r[2];
  assign lane_c_rx_byte      = sym_r[2].data;
  assign lane_c_bit8_kflag   = sym_r[2].bit8;
  assign lane_c_bit9_errflag = sym_r[2].bit9;
  assign lane_d_rx_clock     = clk_out_r[3];
  assign lane_d_rx_byte      = sym_r[3].data;
  assign lane_d_bit8_kflag   = sym_r[3].bit8;
  assign lane_d_bit9_errflag = sym_r[3].bit9;
  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign irq                 = irq_r;

endmodule

/* File: bench/rxpl_lane_out_props.sv */
// concurrent checks on the apb port and lane pins of the receive lane output block
// assumes it is bound into rxpl_lane_out and sees only its ports
`timescale 1ns/1ps
module rxpl_lane_out_props (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // link clocks and lane pins
  input wire logic [3:0]  lane_rec_clk,
  input wire logic        lane_a_rx_clock,
  input wire logic [7:0]  lane_a_rx_byte,
  input wire logic        lane_b_rx_clock,
  input wire logic [7:0]  lane_b_rx_byte
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // steps of an access and of a lane update
  sequence acc_start; psel && penable && $rose(penable); endsequence
  sequence bad_done; pready && (paddr > 8'h0c || paddr[1:0] != 2'h0); endsequence
  sequence byte_a_moves; $changed(lane_a_rx_byte); endsequence
  sequence byte_b_moves; $changed(lane_b_rx_byte); endsequence
  sequence pin_a_edge; $changed(lane_rec_clk[0]); endsequence
  // apb handshake
  a_ready_latency: assert property (acc_start |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready stray");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr stray");
  a_unmapped_err: assert property (bad_done |-> pslverr) else $error("no pslverr");
  a_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data");
  a_mapped_ok: assert property (pready && !(paddr > 8'h0c) && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped pslverr");
  // lane data leads its clock edge by one cycle, and the lane a clock follows each pin edge
  a_a_data_leads: assert property (byte_a_moves |=> $changed(lane_a_rx_clock))
    else $error("lane a clock did not follow data");
  a_b_data_leads: assert property (byte_b_moves |=> $changed(lane_b_rx_clock))
    else $error("lane b clock did not follow data");
  a_clk_follows: assert property (pin_a_edge |-> ##[3:6] $changed(lane_a_rx_clock))
    else $error("lane a clock missed a pin edge");
endmodule

bind rxpl_lane_out rxpl_lane_out_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lane_rec_clk(lane_rec_clk), .lane_a_rx_clock(lane_a_rx_clock),
  .lane_a_rx_byte(lane_a_rx_byte), .lane_b_rx_clock(lane_b_rx_clock),
  .lane_b_rx_byte(lane_b_rx_byte));

/* File: bench/rxpl_host_model.sv */
// host side model: captures the four lanes as one word on both lane a clock edges
// assumes all lanes are timed by the lane a clock or run in phase with it
`timescale 1ns/1ps
module rxpl_host_model (
  // capture enable and lane pins
  input wire logic            en,
  input wire logic            clk,
  input wire logic [3:0][7:0] rxb,
  input wire logic [3:0]      k8,
  input wire logic [3:0]      e9
);
  logic [39:0] hq[$];
  // ddr capture, lane a in the low byte and control bit 0
  always @(clk) if (en) hq.push_back({e9, k8, rxb});
endmodule

/* File: bench/rxpl_lane_out_tb.sv */
// self-checking bench for the receive lane output block
// assumes the host model file and the checker file are compiled alongside
`timescale 1ns/1ps
module rxpl_lane_out_tb;
  logic            pclk, presetn, psel, penable, pwrite, irq, pready, pslverr, en, e;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, q, seed;
  logic [3:0]      rclk;
  logic [3:0][9:0] code;
  logic [63:0]     r;
  logic [39:0]     cur, xq[$], mq[$];
  wire  [3:0]      oclk, k8, e9;
  wire  [3:0][7:0] ob;
  int              n_errors, comparisons, cyc;
  logic [9:0]      dc[6] = '{10'h17c, 10'h283, 10'h155, 10'h17c, 10'h17c, 10'h000};
  logic [7:0]      db[6] = '{8'hbc, 8'hbc, 8'hb5, 8'hbc, 8'h00, 8'h00};
  logic [5:0]      kv = 6'h0b;

  rxpl_lane_out uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_rec_clk(rclk), .lane_rx_code(code), .irq(irq),
    .lane_a_rx_clock(oclk[0]), .lane_a_rx_byte(ob[0]), .lane_a_bit8_kflag(k8[0]),
    .lane_a_bit9_errflag(e9[0]), .lane_b_rx_clock(oclk[1]), .lane_b_rx_byte(ob[1]),
    .lane_b_bit8_kflag(k8[1]), .lane_b_bit9_errflag(e9[1]), .lane_c_rx_clock(oclk[2]),
    .lane_c_rx_byte(ob[2]), .lane_c_bit8_kflag(k8[2]), .lane_c_bit9_errflag(e9[2]),
    .lane_d_rx_clock(oclk[3]), .lane_d_rx_byte(ob[3]), .lane_d_bit8_kflag(k8[3]),
    .lane_d_bit9_errflag(e9[3]));
  rxpl_host_model host (.en(en), .clk(oclk[0]), .rxb(ob), .k8(k8), .e9(e9));

  // system clock and hang guard
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // raw mode: lanes in m take the code group bits unchanged
  function automatic logic [39:0] rawx(logic [39:0] p, logic [3:0][9:0] c, logic [3:0] m);
    for (int i = 0; i < 4; i++) if (m[i]) begin
      p[8*i+:8] = c[i][7:0];
      p[32+i] = c[i][8];
      p[36+i] = c[i][9];
    end
    return p;
  endfunction
  task chk(input string nm, input logic [39:0] s, input logic [39:0] x);
    comparisons++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk("read", {e, q}, {xe, x});
  endtask
  // one half period of the selected lane clocks with a new code group
  task sym(input logic [3:0][9:0] c, input logic [3:0] m);
    @(posedge pclk);
    code <= c;
    rclk <= rclk ^ m;
    repeat (3) @(posedge pclk);
  endtask
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  task tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {pclk, psel, penable, pwrite, en, rclk, paddr, pwdata, code} = '0;
    seed = 32'h000162c4;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, an unmapped place, code mode on
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h08, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'h1);
    rd(8'h00, 32'h1, 1'b0);
    en = 1'b1;
    // decoded symbols: k-chars, data, disparity error, invalid code
    for (int i = 0; i < 6; i++) begin
      sym({4{dc[i]}}, 4'hf);
      xq.push_back({{4{i > 3}}, {4{kv[i]}}, {4{db[i]}}});
      mq.push_back(i > 3 ? 40'hf000000000 : '1);
    end
    // status events: masked, unmasked, cleared by read
    settle;
    chk("irq", irq, 1'b0);
    apb(1'b1, 8'h08, 32'hff);
    settle;
    chk("irq", irq, 1'b1);
    rd(8'h04, 32'hff, 1'b0);
    settle;
    chk("irq", irq, 1'b0);
    rd(8'h04, 32'h0, 1'b0);
    // raw mode, random code groups, all lanes clocked
    apb(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 16; i++) begin
      r = i == 0 ? '1 : {rnd(), rnd()};
      sym(r[39:0], 4'hf);
      cur = rawx(cur, r[39:0], 4'hf);
      xq.push_back(cur);
      mq.push_back('1);
    end
    // only lane a clocked: sync high times all lanes, sync low only lane a
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, 8'h00, j ? 32'h0 : 32'h2);
      for (int i = 0; i < 5; i++) begin
        r = {rnd(), rnd()};
        sym(r[39:0], 4'h1);
        cur = rawx(cur, r[39:0], j ? 4'h1 : 4'hf);
        xq.push_back(cur);
        mq.push_back('1);
      end
      settle;
      if (j == 0) chk("clock copy", oclk[3:1], {3{oclk[0]}});
    end
    chk("captures", host.hq.size(), xq.size());
    for (int i = 0; i < xq.size() && i < host.hq.size(); i++)
      chk("word", host.hq[i] & mq[i], xq[i] & mq[i]);
    tally_and_finish;
  end
endmodule
